// ===== hdl/vcl_loader.sv
`timescale 1ns/1ps
`include "vcl_params.svh"
module vcl_loader #(
  parameter int FLASH_AW = 21
) (
  // Clock and resets
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  input  wire logic                 i_por_n,
  // Program flash read port
  output vcl_pkg::vcl_flash_req_t   o_flash_req,
  input  wire logic [7:0]           i_flash_data,
  // Runtime configuration writes
  input  vcl_pkg::vcl_cfg_wr_t      i_cfg_wr,
  // Configuration outputs
  output logic [7:0]                o_cfg_word1_low,
  output logic [7:0]                o_cfg_word1_high,
  output logic [7:0]                o_cfg_word2_low,
  output logic [7:0]                o_cfg_word2_high,
  output logic [7:0]                o_cfg_word3_low,
  output logic [7:0]                o_cfg_word3_high,
  output logic                      o_load_done,
  output logic                      o_core_rstn
);
  import vcl_pkg::*;

  logic [7:0]  cfg_reg   [6];
  logic [7:0]  wonce_reg [6];
  vcl_state_t  state_reg, state_next;
  logic [2:0]  idx_reg;
  logic [1:0]  lat_reg;
  logic        done_reg, core_reg;
  logic        rd_reg;
  logic [FLASH_AW-1:0] addr_reg;
  logic        rst_any_n;

  // Only power-on reset restarts loading; i_rstn alone holds the core
  assign rst_any_n = i_por_n;

  // Lowest configuration byte sits eight bytes below the top
  wire [FLASH_AW-1:0] base_addr = {FLASH_AW{1'b1}}
                     - FLASH_AW'(`VCL_TOP_OFFSET) + FLASH_AW'(1);

  // Decode runtime writes into the configuration space
  wire [21:0] wr_off  = i_cfg_wr.addr - `VCL_CFG_BASE;
  wire        wr_hit  = i_cfg_wr.we && done_reg &&
                        (i_cfg_wr.addr >= `VCL_CFG_BASE) &&
                        (wr_off < 22'(`VCL_CFG_BYTES));
  wire [2:0]  wr_idx  = wr_off[2:0];
  wire [7:0]  imp_msk = wr_idx[0] ? `VCL_HI_IMPL_MASK
                                  : `VCL_LO_IMPL_MASK;
  wire        lat_end = (lat_reg == `VCL_FLASH_LAT);
  wire        last    = (idx_reg == `VCL_CFG_BYTES - 3'h1);

  // Next fetch index; the address register must follow this one, since
  // the old index would refetch the byte that was just taken
  wire        load_step = (state_reg == VCL_ST_WAIT) && lat_end;
  wire [2:0]  idx_next  = (load_step && !last) ? idx_reg + 3'h1
                                               : idx_reg;

  // Loader sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VCL_ST_CLEAR: state_next = VCL_ST_REQ;
      VCL_ST_REQ:   state_next = VCL_ST_WAIT;
      VCL_ST_WAIT:  if (lat_end) begin
        state_next = last ? VCL_ST_DONE : VCL_ST_REQ;
      end
      VCL_ST_DONE:  state_next = VCL_ST_DONE;
      default:      state_next = VCL_ST_CLEAR;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!rst_any_n) begin
      state_reg <= VCL_ST_CLEAR;
      idx_reg   <= 3'h0;
      lat_reg   <= 2'h0;
      done_reg  <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      rd_reg    <= (state_next == VCL_ST_REQ);
      addr_reg  <= base_addr + FLASH_AW'(idx_next);
      lat_reg   <= (state_reg == VCL_ST_WAIT) ? lat_reg + 2'h1 : 2'h0;
      idx_reg   <= idx_next;
      done_reg  <= (state_next == VCL_ST_DONE);
    end
  end

  // Cells: cleared on power-on, loaded once, then write-once
  always_ff @(posedge i_clk_sys) begin
    for (int k = 0; k < 6; k++) begin
      if (!rst_any_n) begin
        cfg_reg[k]   <= `VCL_UNPROG;
        wonce_reg[k] <= 8'h00;
      end else if (state_reg == VCL_ST_WAIT && lat_end &&
                   idx_reg == 3'(k)) begin
        cfg_reg[k]   <= i_flash_data | ~(k[0] ? `VCL_HI_IMPL_MASK
                                               : `VCL_LO_IMPL_MASK);
        wonce_reg[k] <= ~i_flash_data;
      end else if (wr_hit && wr_idx == 3'(k)) begin
        // Zero bit means programmed; only untouched cells take it
        cfg_reg[k]   <= cfg_reg[k] & ~(~i_cfg_wr.data & imp_msk
                                       & ~wonce_reg[k]);
        wonce_reg[k] <= wonce_reg[k] | (imp_msk & ~i_cfg_wr.data);
      end
    end
  end

  // Core held in reset until loading ends
  always_ff @(posedge i_clk_sys) begin
    if (!i_por_n) begin
      core_reg <= 1'b0;
    end else begin
      core_reg <= done_reg && i_rstn;
    end
  end

  assign o_flash_req.rd   = rd_reg;
  assign o_flash_req.addr = addr_reg;
  assign o_cfg_word1_low  = cfg_reg[0];
  assign o_cfg_word1_high = cfg_reg[1];
  assign o_cfg_word2_low  = cfg_reg[2];
  assign o_cfg_word2_high = cfg_reg[3];
  assign o_cfg_word3_low  = cfg_reg[4];
  assign o_cfg_word3_high = cfg_reg[5];
  assign o_load_done      = done_reg;
  assign o_core_rstn      = core_reg;

  // Checks
  sequence load_seq;
    !i_por_n ##1 i_por_n;
  endsequence

  por_clear_a: assert property (@(posedge i_clk_sys)
    !i_por_n |=> cfg_reg[0] == 8'hFF && cfg_reg[5] == 8'hFF)
    else $error("cells not set to one on power-on");

  core_hold_a: assert property (@(posedge i_clk_sys)
    o_core_rstn |-> o_load_done)
    else $error("core released before load done");

  no_reload_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) o_load_done |=> o_load_done)
    else $error("reload after non power-on reset");

  load_ends_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) load_seq |-> ##[1:40] o_load_done)
    else $error("load did not finish");

  hi_nibble_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    o_load_done |-> cfg_reg[1][7:4] == 4'hF && cfg_reg[3][7:4] == 4'hF
                    && cfg_reg[5][7:4] == 4'hF)
    else $error("unimplemented nibble changed");

  wr_once_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    o_load_done && !cfg_reg[2][0] |=> !cfg_reg[2][0])
    else $error("programmed bit reverted");

  addr_top_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    rd_reg |-> addr_reg >= base_addr)
    else $error("fetch below configuration words");

  wr_clear_only_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    o_load_done |=> (cfg_reg[0] & ~$past(cfg_reg[0])) == 8'h00)
    else $error("cell went from programmed to one");

  // Fetch address must track the byte slot being filled
  fetch_addr_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    rd_reg |-> addr_reg == base_addr + FLASH_AW'(idx_reg))
    else $error("fetch address does not match byte slot");

  // Flash needs its full latency between two reads
  sequence fetch_gap_s;
    !rd_reg [*3];
  endsequence

  fetch_gap_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) rd_reg |=> fetch_gap_s)
    else $error("flash read issued too soon");

  // Core may leave reset one cycle after loading ends, never with it
  sequence done_rise_s;
    !o_load_done ##1 o_load_done;
  endsequence

  core_late_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) done_rise_s |-> !o_core_rstn)
    else $error("core released in the cycle loading ended");

  // Warm reset holds the core and never touches the flash again
  warm_hold_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) !i_rstn |=> !o_core_rstn)
    else $error("core not held by warm reset");

  no_refetch_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n) o_load_done |-> !rd_reg)
    else $error("flash read after loading ended");

  // Cells keep their values through warm reset when nothing writes
  cell_keep_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    o_load_done && !i_rstn && !i_cfg_wr.we |=>
      $stable(cfg_reg[0]) && $stable(cfg_reg[5]))
    else $error("cell changed during warm reset");

  // Accepted writes fall inside the six implemented bytes
  wr_range_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_por_n)
    wr_hit |-> i_cfg_wr.addr[21:3] == 19'h6_0000
               && i_cfg_wr.addr[2:0] <= 3'h5)
    else $error("write accepted outside configuration space");
endmodule // vcl_loader

// ===== hdl/vcl_params.svh
`ifndef VCL_PARAMS_SVH
`define VCL_PARAMS_SVH
// Configuration space base in the program address map
`define VCL_CFG_BASE      22'h30_0000
// Number of configuration bytes copied (three words, six bytes)
`define VCL_CFG_BYTES     3'h6
// Flash offset of the lowest configuration byte below the top of memory
`define VCL_TOP_OFFSET    4'h8
// Erased or unprogrammed state of a configuration byte
`define VCL_UNPROG        8'hFF
// Upper nibble of the high bytes holds no cells
`define VCL_HI_IMPL_MASK  8'h0F
`define VCL_LO_IMPL_MASK  8'hFF
// Flash read latency in system clocks
`define VCL_FLASH_LAT     2'h2
`endif

// ===== hdl/vcl_pkg.sv
package vcl_pkg;
  typedef enum logic [1:0] {
    VCL_ST_CLEAR = 2'b00,
    VCL_ST_REQ   = 2'b01,
    VCL_ST_WAIT  = 2'b10,
    VCL_ST_DONE  = 2'b11
  } vcl_state_t;

  // Flash read request toward the program array
  typedef struct packed {
    logic        rd;
    logic [20:0] addr;
  } vcl_flash_req_t;

  // Runtime write toward the configuration space
  typedef struct packed {
    logic        we;
    logic [21:0] addr;
    logic [7:0]  data;
  } vcl_cfg_wr_t;
endpackage

// ===== verif/vcl_flash_model.sv
`timescale 1ns/1ps
module vcl_flash_model #(
  parameter logic [47:0] P_IMG = 48'h0
) (
  // Clock and request
  input  wire logic               i_clk_sys,
  input  vcl_pkg::vcl_flash_req_t i_req,
  // Read data
  output logic [7:0]              o_data
);
  import vcl_pkg::*;
  logic [1:0] rd_reg = 2'h0;
  logic [2:0] idx_reg = 3'h0;
  logic       hit_reg = 1'b0;
  // Data held two cycles, then inverted so stale bytes never pass;
  // only the lowest six slots of the top eight bytes of the array answer
  always @(posedge i_clk_sys) begin
    rd_reg <= {rd_reg[0], i_req.rd};
    if (i_req.rd) begin
      idx_reg <= i_req.addr[2:0];
      hit_reg <= (&i_req.addr[20:3]) && (i_req.addr[2:0] <= 3'h5);
    end
    o_data <= (|rd_reg && hit_reg) ? P_IMG[8*idx_reg+:8] : ~o_data;
  end
  initial o_data = 8'h00;
endmodule // vcl_flash_model

// ===== verif/vcl_loader_tb_top.sv
`timescale 1ns/1ps
module vcl_loader_tb_top;
  import vcl_pkg::*;
  // High nibbles of odd bytes all ones
  localparam logic [47:0] IMG = 48'hFEE8_F9C3_F57A;
  logic i_clk_sys, i_rstn, i_por_n;
  vcl_flash_req_t flash_req;
  vcl_cfg_wr_t i_cfg_wr;
  logic [7:0] fdata, w1l, w1h, w2l, w2h, w3l, w3h;
  logic o_load_done, o_core_rstn;
  logic [47:0] cells, exp_cells;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  assign cells = {w3h, w3l, w2h, w2l, w1h, w1l};
  vcl_flash_model #(.P_IMG(IMG)) i_vcl_flash_model (.i_clk_sys(i_clk_sys),
    .i_req(flash_req), .o_data(fdata));
  vcl_loader i_vcl_loader (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_por_n(i_por_n), .o_flash_req(flash_req), .i_flash_data(fdata),
    .i_cfg_wr(i_cfg_wr), .o_cfg_word1_low(w1l), .o_cfg_word1_high(w1h),
    .o_cfg_word2_low(w2l), .o_cfg_word2_high(w2h), .o_cfg_word3_low(w3l),
    .o_cfg_word3_high(w3h), .o_load_done(o_load_done),
    .o_core_rstn(o_core_rstn));
  // Clock and hang guard
  initial begin
    i_clk_sys = 0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    i_cfg_wr = {1'b1, a, d};
    @(posedge i_clk_sys);
    #1;
  endtask
  // Power-on: cells forced high, then loaded before core release
  task automatic t_por();
    int n;
    i_por_n = 0;
    i_rstn = 0;
    repeat (6) @(posedge i_clk_sys);
    #1 chk(cells, {6{8'hFF}});
    chk({o_load_done, o_core_rstn}, 48'h0);
    i_por_n = 1;
    i_rstn = 1;
    // A write while loading must be dropped
    repeat (8) @(posedge i_clk_sys);
    #1 wr(22'h30_0000, 8'h00);
    i_cfg_wr.we = 1'b0;
    for (n = 0; n < 40 && o_load_done !== 1'b1; n++) @(posedge i_clk_sys);
    #1 chk(cells, IMG);
    @(posedge i_clk_sys);
    #1 chk({o_load_done, o_core_rstn}, 48'h3);
    $display("power-on load test ended");
  endtask
  // Bits program once; high nibbles and stray addresses ignored
  task automatic t_write();
    exp_cells = IMG;
    wr(22'h30_0000, 8'h00);
    wr(22'h30_0000, 8'hFF);
    wr(22'h30_0001, 8'h00);
    wr(22'h30_0002, 8'hFE);
    wr(22'h30_0002, 8'hFF);
    wr(22'h30_0006, 8'h00);
    wr(22'h2F_FFFD, 8'h00);
    i_cfg_wr.we = 1'b0;
    exp_cells[23:0] = {IMG[23:16] & 8'hFE, IMG[15:8] & 8'hF0, 8'h00};
    chk(cells, exp_cells);
    $display("write-once test ended");
  endtask
  // Warm reset keeps cells and fetches nothing
  task automatic t_warm();
    i_rstn = 0;
    repeat (4) begin
      @(posedge i_clk_sys);
      #1 chk({flash_req.rd, o_core_rstn}, 48'h0);
    end
    chk(cells, exp_cells);
    i_rstn = 1;
    @(posedge i_clk_sys);
    #1 chk({o_load_done, o_core_rstn}, 48'h3);
    $display("warm reset test ended");
  endtask
  initial begin
    i_rstn = 0;
    i_por_n = 0;
    i_cfg_wr = '0;
    t_por();
    t_write();
    t_warm();
    t_por();
    wrap_up();
  end
endmodule // vcl_loader_tb_top
